/* logic/serial_port.sv */
`timescale 1ns/1ps
module serial_port
    import serial_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Dedicated transmit pin
    output logic            tx_out_pin_o,
    output logic            tx_out_pin_oe_n,
    output logic            tx_pullup_en,
    // Shared pin
    input  wire logic       shared_serial_pin_i,
    output logic            shared_serial_pin_o,
    output logic            shared_serial_pin_oe_n,
    // Requests
    output logic            irq,
    output logic            wakeup
);
    import serial_pkg::*;

    // ==========================================================
    // Reset and pin synchronisers
    logic       rst_meta;                  // First reset stage
    logic       rst_sync_n;                // Released reset
    logic       rx_meta;                   // First pin stage
    logic       rx_line;                   // Synchronised pin

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Idle line is high, so synchroniser resets high
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_meta <= 1'b1;
            rx_line <= 1'b1;
        end else begin
            rx_meta <= shared_serial_pin_i;
            rx_line <= rx_meta;
        end
    end

    // ==========================================================
    // Registers
    logic [7:0] ctrl1, ctrl2, ctrl3, fifo_ctl, baud_hi, baud_lo;
    logic [7:0] tx_hold;                   // Queued character
    logic       tx_hold_b8;                // Queued ninth bit
    logic       tx_empty, tx_idle;         // Transmit flags
    logic       par_err, noise, frm_err, ovr_err;
    logic       status_seen;               // Status read armed
    logic [8:0] fifo_mem [FIFO_DEPTH];     // Receive store
    logic [1:0] rd_ptr, wr_ptr;
    logic [2:0] fill;                      // Characters held
    logic       rx_busy;

    // Decodes
    wire unit_en  = ctrl1[C1_UNIT_EN];
    wire single   = ctrl3[C3_SINGLE];
    wire rx_en    = unit_en & ctrl2[C2_RX_EN];
    wire tx_en    = unit_en & ctrl2[C2_TX_EN] & ~(single & rx_en);
    wire len9     = ctrl1[C1_LEN9];
    wire par_en   = ctrl1[C1_PAR_EN];
    wire [1:0] par_type = {ctrl1[C1_PAR_HI], ctrl1[C1_PAR_LO]};
    wire stop2    = ctrl2[C2_STOP2];
    // sixteen-bit divisor, one tick per sixteenth of a bit
    wire [15:0] divisor = {baud_hi, baud_lo};
    wire hit_data   = (addr == ADDR_DATA);
    wire hit_status = (addr == ADDR_STATUS);
    wire data_wr    = wr & hit_data;
    wire data_rd    = rd & hit_data;
    // status read then data access clears errors
    wire err_clear  = status_seen & (data_wr | data_rd);

    // Parity for a nine-bit word under the configured type
    function automatic logic par_bit(input logic [8:0] d,
                                     input logic       l9,
                                     input logic [1:0] t);
        logic x;
        x = ^d[7:0] ^ (l9 & d[8]);
        unique case (t)
            PAR_EVEN:  par_bit = x;
            PAR_ODD:   par_bit = ~x;
            PAR_MARK:  par_bit = 1'b1;
            PAR_SPACE: par_bit = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Baud tick generator, shared by both directions
    logic [15:0] baud_cnt;
    logic        tick;
    wire         baud_wrap = (baud_cnt >= divisor);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            baud_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else begin
            baud_cnt <= baud_wrap ? 16'h0000 : baud_cnt + 16'h0001;
            tick     <= baud_wrap & unit_en;
        end
    end

    // ==========================================================
    // Receive trigger level
    wire [1:0] trig_sel = {fifo_ctl[FC_TRIG_HI], fifo_ctl[FC_TRIG_LO]};
    wire [2:0] trig_lvl = (trig_sel == 2'h0) ? 3'h1 :
                          (trig_sel == 2'h1) ? 3'h2 : FIFO_FULL;
    wire rx_ready = (fill != 3'h0) & (fill >= trig_lvl);
    wire [7:0] status = {par_err, noise, frm_err, ovr_err,
                         ~rx_busy, rx_ready, tx_idle, tx_empty};

    // ==========================================================
    // Transmitter
    line_state_t tx_st;
    logic [3:0]  tx_sub, tx_bit;
    logic [8:0]  tx_shift;
    logic        tx_line;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_st    <= ST_IDLE;
            tx_sub   <= 4'h0;
            tx_bit   <= 4'h0;
            tx_shift <= 9'h000;
            tx_line  <= 1'b1;
        end else if (!tx_en) begin
            tx_st   <= ST_IDLE;
            tx_line <= 1'b1;
        end else if (tx_st == ST_IDLE) begin
            tx_line <= ~ctrl1[C1_BREAK];
            if (!tx_empty) begin
                tx_st    <= ST_START;
                tx_shift <= {tx_hold_b8, tx_hold};
                tx_sub   <= 4'h0;
                tx_line  <= 1'b0;
            end
        end else if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == LAST_TICK) begin
                unique case (tx_st)
                    ST_START: begin
                        tx_st   <= ST_DATA;
                        tx_bit  <= 4'h0;
                        tx_line <= tx_shift[0];
                    end
                    ST_DATA: begin
                        // lsb first, eight or nine bits
                        if (tx_bit + 4'h1 == (len9 ? BITS_9 : BITS_8)) begin
                            tx_st   <= par_en ? ST_PARITY : ST_STOP;
                            tx_line <= par_en ?
                                par_bit(tx_shift, len9,
                                        par_type) : 1'b1;
                            tx_bit  <= 4'h0;
                        end else begin
                            tx_bit  <= tx_bit + 4'h1;
                            tx_line <= tx_shift[tx_bit + 4'h1];
                        end
                    end
                    ST_PARITY: begin
                        tx_st   <= ST_STOP;
                        tx_line <= 1'b1;
                        tx_bit  <= 4'h0;
                    end
                    ST_STOP: begin
                        if (stop2 && tx_bit == 4'h0) begin
                            tx_bit <= 4'h1;
                        end else begin
                            tx_st <= ST_IDLE;
                        end
                    end
                    default: tx_st <= ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Receiver
    line_state_t rx_st;
    logic [3:0]  rx_sub, rx_bit;
    logic [8:0]  rx_shift;
    logic [2:0]  samp;                     // Three mid-bit samples
    logic        rx_noisy, rx_par_bad;
    wire         vote = (samp[0] & samp[1]) | (samp[1] & samp[2]) |
                        (samp[0] & samp[2]);
    wire         split = (samp != 3'h0) & (samp != 3'h7);
    wire         bit_end = tick & (rx_sub == LAST_TICK);
    wire         rx_done = bit_end & (rx_st == ST_STOP);
    // address mode keeps only msb-set characters
    wire [8:0]   rx_word = rx_shift;
    wire         rx_msb  = len9 ? rx_word[8] : rx_word[7];
    wire         rx_keep = ~ctrl2[C2_ADDR_EN] | rx_msb;
    wire         push = rx_done & rx_keep & (fill != FIFO_FULL);
    wire         pop  = data_rd & (fill != 3'h0);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_st      <= ST_IDLE;
            rx_sub     <= 4'h0;
            rx_bit     <= 4'h0;
            rx_shift   <= 9'h000;
            samp       <= 3'h7;
            rx_noisy   <= 1'b0;
            rx_par_bad <= 1'b0;
            rx_busy    <= 1'b0;
        end else if (!rx_en) begin
            rx_st   <= ST_IDLE;
            rx_busy <= 1'b0;
        end else if (rx_st == ST_IDLE) begin
            rx_noisy   <= 1'b0;
            rx_par_bad <= 1'b0;
            // falling line marks a start bit
            if (!rx_line) begin
                rx_st   <= ST_START;
                rx_sub  <= 4'h0;
                rx_busy <= 1'b1;
            end
        end else if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            // Sample around the bit centre
            if (rx_sub >= HALF_BIT && rx_sub <= HALF_BIT + 4'h2) begin
                samp <= {samp[1:0], rx_line};
            end
            if (rx_sub == LAST_TICK) begin
                rx_noisy <= rx_noisy | split;
                unique case (rx_st)
                    ST_START: begin
                        rx_st  <= vote ? ST_IDLE : ST_DATA;
                        rx_busy <= ~vote;
                        rx_bit <= 4'h0;
                    end
                    ST_DATA: begin
                        rx_shift[rx_bit] <= vote;
                        if (rx_bit + 4'h1 == (len9 ? BITS_9 : BITS_8)) begin
                            rx_st <= par_en ? ST_PARITY : ST_STOP;
                            if (!len9) begin
                                rx_shift[8] <= 1'b0;
                            end
                        end else begin
                            rx_bit <= rx_bit + 4'h1;
                        end
                    end
                    ST_PARITY: begin
                        rx_st      <= ST_STOP;
                        rx_par_bad <= vote != par_bit(rx_shift, len9,
                                                      par_type);
                    end
                    ST_STOP: begin
                        rx_st   <= ST_IDLE;
                        rx_busy <= 1'b0;
                    end
                    default: rx_st <= ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // four-deep receive store
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_ptr <= 2'h0;
            wr_ptr <= 2'h0;
            fill   <= 3'h0;
        end else begin
            if (push) begin
                fifo_mem[wr_ptr] <= rx_word;
                wr_ptr <= wr_ptr + 2'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 2'h1;
            end
            fill <= fill + {2'h0, push} - {2'h0, pop};
        end
    end

    // ==========================================================
    // Flags and control registers; error flag set wins over clear
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl1 <= ZERO_BYTE;  ctrl2    <= ZERO_BYTE;
            ctrl3 <= ZERO_BYTE;  fifo_ctl <= ZERO_BYTE;
            baud_hi <= ZERO_BYTE; baud_lo <= ZERO_BYTE;
            tx_hold <= ZERO_BYTE; tx_hold_b8 <= 1'b0;
            tx_empty <= STATUS_RESET[0];
            tx_idle  <= STATUS_RESET[1];
            par_err <= 1'b0; noise <= 1'b0;
            frm_err <= 1'b0; ovr_err <= 1'b0;
            status_seen <= 1'b0;
        end else begin
            if (wr && addr == ADDR_CTRL1)    ctrl1    <= wdata;
            if (wr && addr == ADDR_CTRL2)    ctrl2    <= wdata;
            if (wr && addr == ADDR_CTRL3)    ctrl3    <= wdata;
            if (wr && addr == ADDR_FIFO_CTL) fifo_ctl <= wdata;
            if (wr && addr == ADDR_BAUD_HI)  baud_hi  <= wdata;
            if (wr && addr == ADDR_BAUD_LO)  baud_lo  <= wdata;
            if (rd && hit_status) status_seen <= 1'b1;
            else if (data_wr | data_rd) status_seen <= 1'b0;
            if (data_wr) begin
                tx_hold    <= wdata;
                tx_hold_b8 <= ctrl1[C1_TX_BIT8];
                tx_empty   <= 1'b0;
                tx_idle    <= 1'b0;
            end else if (tx_en && tx_st == ST_IDLE && !tx_empty) begin
                tx_empty <= 1'b1;
            end else if (tx_en && tx_st == ST_IDLE && tx_empty) begin
                tx_idle <= 1'b1;
            end
            if (rx_done && fill == FIFO_FULL && rx_keep) begin
                ovr_err <= 1'b1;
            end else if (err_clear) begin
                ovr_err <= 1'b0;
            end
            if (push) begin
                par_err <= par_err | rx_par_bad;
                noise   <= noise | rx_noisy | split;
                frm_err <= frm_err | ~vote;
            end else if (err_clear) begin
                par_err <= 1'b0;
                noise   <= 1'b0;
                frm_err <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read data, pins and requests, all registered
    wire [8:0] head = fifo_mem[rd_ptr];
    wire [7:0] ctrl1_rd = {ctrl1[7:2], head[8], 1'b0};
    wire [7:0] next_rdata =
        (addr == ADDR_STATUS)   ? status :
        (addr == ADDR_CTRL1)    ? ctrl1_rd :
        (addr == ADDR_CTRL2)    ? ctrl2 :
        (addr == ADDR_CTRL3)    ? ctrl3 :
        (addr == ADDR_DATA)     ? head[7:0] :
        (addr == ADDR_BAUD_HI)  ? baud_hi :
        (addr == ADDR_BAUD_LO)  ? baud_lo :
        (addr == ADDR_FIFO_CTL) ? fifo_ctl :
        (addr == ADDR_RX_COUNT) ? {5'h00, fill} : ZERO_BYTE;
    // four interrupt conditions, gated by enables
    wire next_irq = (ctrl2[C2_RX_IE] & (rx_ready | ovr_err)) |
                    (ctrl2[C2_IDLE_IE] & tx_idle) |
                    (ctrl2[C2_EMPTY_IE] & tx_empty);
    wire drive_shared = single & tx_en;
    wire drive_tx     = tx_en & (~single | ctrl3[C3_MIRROR_TX]);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata                  <= ZERO_BYTE;
            irq                    <= 1'b0;
            wakeup                 <= 1'b0;
            tx_out_pin_o           <= 1'b1;
            tx_out_pin_oe_n        <= 1'b1;
            tx_pullup_en           <= 1'b1;
            shared_serial_pin_o    <= 1'b1;
            shared_serial_pin_oe_n <= 1'b1;
        end else begin
            rdata  <= rd ? next_rdata : ZERO_BYTE;
            irq    <= next_irq;
            // low receive line wakes when enabled, for as long as it stays low
            wakeup <= unit_en & ctrl2[C2_WAKE_EN] & ~rx_line;
            tx_out_pin_o           <= tx_line;
            tx_out_pin_oe_n        <= ~drive_tx;
            tx_pullup_en           <= ~drive_tx;
            // shared pin is input unless transmit owns it
            shared_serial_pin_o    <= tx_line;
            shared_serial_pin_oe_n <= ~drive_shared;
        end
    end

endmodule

/* common/serial_pkg.sv */
// Behaviour
// - Eight or nine data bits per character.
// - Even, odd, mark, space or no parity.
// - One or two stop bits end frame.
// - Sixteen-bit divisor from high/low bytes.
// - Four-deep receive store before software.
// - One queued transmit character at most.
// - Flag parity, framing, noise, overrun errors.
// - Address mode: only msb-set characters interrupt.
// - Interrupt requests for four tx/rx conditions.
// - Independent transmit and receive enables outside single-wire.
// - Disabled direction leaves its pin floating.
// - Transmit pin pull-high off while transmitting.
// - Single-wire select shares one pin.
// - Single-wire, receive enabled: pin is input.
// - Single-wire, only transmit: pin drives output.
// - Both enabled single-wire: receive wins.
// - Single-wire transmit may also drive tx pin.
// - Written character shifted out lsb first.
// - Received bits assembled lsb first, then buffered.
// - One data register for both directions.
// - Receive pin activity wakes when enabled.
// - Errors clear on status read then data access.
// - Data-ready flag at trigger level.
package serial_pkg;

    // ==========================================================
    // Register indices
    localparam logic [3:0] ADDR_STATUS   = 4'h0;
    localparam logic [3:0] ADDR_CTRL1    = 4'h1;
    localparam logic [3:0] ADDR_CTRL2    = 4'h2;
    localparam logic [3:0] ADDR_CTRL3    = 4'h3;
    localparam logic [3:0] ADDR_DATA     = 4'h4;
    localparam logic [3:0] ADDR_BAUD_HI  = 4'h5;
    localparam logic [3:0] ADDR_BAUD_LO  = 4'h6;
    localparam logic [3:0] ADDR_FIFO_CTL = 4'h7;
    localparam logic [3:0] ADDR_RX_COUNT = 4'h8;

    // ==========================================================
    // Reset values
    localparam logic [7:0] STATUS_RESET  = 8'h0b;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;

    // ==========================================================
    // Control one fields
    localparam int C1_UNIT_EN   = 7;
    localparam int C1_LEN9      = 6;
    localparam int C1_PAR_EN    = 5;
    localparam int C1_PAR_HI    = 4;
    localparam int C1_PAR_LO    = 3;
    localparam int C1_BREAK     = 2;
    localparam int C1_RX_BIT8   = 1;
    localparam int C1_TX_BIT8   = 0;
    // Control two fields
    localparam int C2_TX_EN     = 7;
    localparam int C2_RX_EN     = 6;
    localparam int C2_STOP2     = 5;
    localparam int C2_ADDR_EN   = 4;
    localparam int C2_WAKE_EN   = 3;
    localparam int C2_RX_IE     = 2;
    localparam int C2_IDLE_IE   = 1;
    localparam int C2_EMPTY_IE  = 0;
    // Control three and fifo control fields
    localparam int C3_SINGLE    = 0;
    localparam int FC_TRIG_HI   = 1;
    localparam int FC_TRIG_LO   = 0;
    // Control three extra bit: mirror single-wire data on tx pin
    localparam int C3_MIRROR_TX = 1;

    // Parity type codes
    localparam logic [1:0] PAR_EVEN  = 2'h0;
    localparam logic [1:0] PAR_ODD   = 2'h1;
    localparam logic [1:0] PAR_MARK  = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;

    // ==========================================================
    // Sizes
    localparam int         FIFO_DEPTH = 4;
    localparam logic [2:0] FIFO_FULL  = 3'h4;
    localparam logic [3:0] HALF_BIT   = 4'h7;
    localparam logic [3:0] LAST_TICK  = 4'hf;
    localparam logic [3:0] BITS_8     = 4'h8;
    localparam logic [3:0] BITS_9     = 4'h9;

    // Serial engine states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_START  = 5'b00010,
        ST_DATA   = 5'b00100,
        ST_PARITY = 5'b01000,
        ST_STOP   = 5'b10000
    } line_state_t;

endpackage

/* verification/serial_port_sva.sv */
`timescale 1ns/1ps
module serial_port_sva
    import serial_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       tx_out_pin_o,
    input wire logic       tx_out_pin_oe_n,
    input wire logic       tx_pullup_en,
    input wire logic       shared_serial_pin_o,
    input wire logic       shared_serial_pin_oe_n,
    input wire logic       wakeup
);
    // ==========================================
    // Shadow controls, judged only once settled, except in a_wake_gate
    logic [7:0] c1, c2, c3;
    logic [1:0] quiet;  // Cycles since last write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c1 <= 8'h00;
            c2 <= 8'h00;
            c3 <= 8'h00;
            quiet <= 2'h0;
        end else if (wr) begin
            if (addr == ADDR_CTRL1) c1 <= wdata;
            if (addr == ADDR_CTRL2) c2 <= wdata;
            if (addr == ADDR_CTRL3) c3 <= wdata;
            quiet <= 2'h0;
        end else if (quiet != 2'h3) begin
            quiet <= quiet + 2'h1;
        end
    end
    wire on  = quiet == 2'h3 && c1[C1_UNIT_EN];
    wire sw  = c3[C3_SINGLE];
    wire rxe = c2[C2_RX_EN];
    wire txe = c2[C2_TX_EN];
    wire wake_ok = c1[C1_UNIT_EN] && c2[C2_WAKE_EN];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A falling line stays low eight cycles, never a glitch
    sequence s_low_bit;
        !tx_out_pin_o [*8];
    endsequence
    a_read_window: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its window");
    a_start_hold: assert property ($fell(tx_out_pin_o)
        && !tx_out_pin_oe_n |-> s_low_bit) else $error("short low bit");
    a_pullup_off: assert property (!tx_out_pin_oe_n |-> !tx_pullup_en)
        else $error("pull-high left on while driving");
    a_unit_floats: assert property (quiet == 2'h3 && !c1[C1_UNIT_EN]
        |-> tx_out_pin_oe_n && shared_serial_pin_oe_n)
        else $error("pin driven while disabled");
    a_rx_wins: assert property (on && sw && rxe
        |-> shared_serial_pin_oe_n) else $error("shared pin not input");
    a_single_drive: assert property (on && sw && !rxe && txe
        |-> !shared_serial_pin_oe_n) else $error("shared pin not driven");
    a_duplex_tx: assert property (on && !sw && txe
        |-> !tx_out_pin_oe_n && shared_serial_pin_oe_n)
        else $error("full duplex pins wrong");
    a_mirror_copy: assert property (on && sw && !rxe && txe
        && c3[C3_MIRROR_TX] |-> tx_out_pin_o == shared_serial_pin_o)
        else $error("tx pin does not mirror");
    a_wake_gate: assert property (wakeup |-> $past(wake_ok))
        else $error("wake without enable");
endmodule

bind serial_port serial_port_sva chk (.clk, .rst_n, .addr, .wdata, .wr,
    .rd, .rdata, .tx_out_pin_o, .tx_out_pin_oe_n, .tx_pullup_en,
    .shared_serial_pin_o, .shared_serial_pin_oe_n, .wakeup);

/* verification/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer #(
    parameter int BIT_CLKS = 16  // Divisor zero: 16 clocks a bit
) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    // Line idles high between frames
    initial line_out = 1'b1;
    // ==========================================
    // start, data lsb first, parity, stops
    task automatic send(input logic [8:0] d, input int n, input logic pe,
                        input logic pb, input int stops);
        line_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            line_out <= d[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        if (pe) begin
            line_out <= pb;
            repeat (BIT_CLKS) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (BIT_CLKS * stops) @(posedge clk);
    endtask
    // sample mid-bit, lsb first; returns in the stop bit
    task automatic recv(output logic [8:0] d, input int n);
        d = 9'h000;
        @(negedge line_in);
        repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            d[i] = line_in;
            repeat (BIT_CLKS) @(posedge clk);
        end
    endtask
endmodule

/* verification/test_serial_port.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module test_serial_port;
    import serial_pkg::*;
    logic       clk, rst_n, wr, rd, use_shared, peer_out;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v, b;
    logic       tx_o, tx_oe_n, sh_o, sh_oe_n, irq_o;
    logic [8:0] got;
    int         errors, num_checks, cycles;
    // Released tx pin is pulled high; shared wire follows its driver
    wire tx_line = tx_oe_n ? 1'b1 : tx_o;
    wire sh_line = sh_oe_n ? peer_out : sh_o;
    serial_port dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .tx_out_pin_o(tx_o), .tx_out_pin_oe_n(tx_oe_n), .tx_pullup_en(),
        .shared_serial_pin_i(sh_line), .shared_serial_pin_o(sh_o),
        .shared_serial_pin_oe_n(sh_oe_n), .irq(irq_o), .wakeup());
    serial_peer peer (.clk, .line_in(use_shared ? sh_line : tx_line),
        .line_out(peer_out));
    // ==========================================
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic par_of(input logic [7:0] d, input logic [1:0] t);
        return t == PAR_EVEN ? ^d : t == PAR_ODD ? ~^d : t == PAR_MARK;
    endfunction
    task test_regs;
        rd_reg(ADDR_STATUS, v); `CHK(v, STATUS_RESET)
        rd_reg(4'hf, v); `CHK(v, ZERO_BYTE)
        wr_reg(ADDR_BAUD_HI, 8'h12);
        rd_reg(ADDR_BAUD_HI, v); `CHK(v, 8'h12)
        wr_reg(ADDR_BAUD_HI, 8'h00);
        wr_reg(ADDR_BAUD_LO, 8'h00);
        $display("test_regs done");
    endtask
    task test_tx;
        wr_reg(ADDR_CTRL1, 8'h80);
        wr_reg(ADDR_CTRL2, 8'h80);
        fork
            begin
                wr_reg(ADDR_DATA, 8'ha5);
                repeat (8) @(posedge clk);
                wr_reg(ADDR_DATA, 8'h3c);
            end
            begin
                peer.recv(got, 8); `CHK(got, 9'h0a5)
                peer.recv(got, 8); `CHK(got, 9'h03c)
            end
        join
        repeat (40) @(posedge clk);
        wr_reg(ADDR_CTRL1, 8'hc1);
        fork
            wr_reg(ADDR_DATA, 8'h5a);
            begin peer.recv(got, 9); `CHK(got, 9'h15a) end
        join
        repeat (40) @(posedge clk);
        $display("test_tx done");
    endtask
    task test_rx;
        wr_reg(ADDR_CTRL2, 8'h4c);
        for (int t = 0; t < 5; t++) begin
            b = 8'h30 + 8'(t);
            wr_reg(ADDR_CTRL1, {3'b101, t[1:0], 3'b000});
            // Last pass sends even type with the odd bit: a parity error
            peer.send({1'b0, b}, 8, 1'b1, par_of(b, t[1:0]) ^ (t == 4), 1);
            repeat (40) @(posedge clk);
            rd_reg(ADDR_STATUS, v); `CHK(v[7:2], {t == 4, 5'b00011})
            `CHK(irq_o, 1'b1)
            rd_reg(ADDR_DATA, v); `CHK(v, b)
        end
        rd_reg(ADDR_STATUS, v); `CHK(v[7], 1'b0)
        $display("test_rx done");
    endtask
    task test_overrun;
        wr_reg(ADDR_CTRL1, 8'h80);
        for (int i = 0; i < 5; i++) peer.send(9'h040 + 9'(i), 8, 1'b0, 1'b0, 1);
        repeat (40) @(posedge clk);
        rd_reg(ADDR_RX_COUNT, v); `CHK(v, 8'h04)
        rd_reg(ADDR_STATUS, v); `CHK(v[4], 1'b1)
        for (int i = 0; i < 4; i++) begin
            rd_reg(ADDR_DATA, v); `CHK(v, 8'h40 + 8'(i))
        end
        rd_reg(ADDR_STATUS, v); `CHK(v[4], 1'b0)
        $display("test_overrun done");
    endtask
    task test_address;
        wr_reg(ADDR_CTRL2, 8'h5c);
        peer.send(9'h011, 8, 1'b0, 1'b0, 2);
        peer.send(9'h091, 8, 1'b0, 1'b0, 2);
        repeat (40) @(posedge clk);
        rd_reg(ADDR_RX_COUNT, v); `CHK(v, 8'h01)
        rd_reg(ADDR_DATA, v); `CHK(v, 8'h91)
        $display("test_address done");
    endtask
    task test_single;
        use_shared = 1'b1;
        wr_reg(ADDR_CTRL3, 8'h03);
        wr_reg(ADDR_CTRL2, 8'h80);
        fork
            wr_reg(ADDR_DATA, 8'h69);
            begin peer.recv(got, 8); `CHK(got, 9'h069) end
        join
        repeat (40) @(posedge clk);
        wr_reg(ADDR_CTRL2, 8'hc0);
        repeat (8) @(posedge clk);
        wr_reg(ADDR_CTRL1, 8'h00);
        repeat (8) @(posedge clk);
        $display("test_single done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
        use_shared = 1'b0; errors = 0; num_checks = 0; cycles = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_regs();
        test_tx();
        test_rx();
        test_overrun();
        test_address();
        test_single();
        finish_test();
    end
endmodule
